// File: design/aimap_pkg.sv
// Package for the analog input function mapper: register indexes, reset values,
// setting codes, limits and the packed state types.
// Assumes a classic Wishbone slave with 32-bit data; byte address = 4 * index.
package aimap_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indexes; the byte address is four times the index.
  localparam logic [13:0] IDX_IN1_FUNC = 14'h0300;
  localparam logic [13:0] IDX_IN2_FUNC = 14'h0301;
  localparam logic [13:0] IDX_IN1_BIAS = 14'h0302;
  localparam logic [13:0] IDX_IN2_BIAS = 14'h0303;
  localparam logic [13:0] IDX_IN1_MODE = 14'h0304;
  localparam logic [13:0] IDX_IN2_MODE = 14'h0308;
  localparam logic [13:0] IDX_REV_EN = 14'h030a;
  localparam logic [13:0] IDX_IN1_GAIN = 14'h030b;
  localparam logic [13:0] IDX_IN2_GAIN = 14'h030c;
  localparam logic [13:0] IDX_ADD_EN = 14'h0312;
  localparam logic [13:0] IDX_ALT_SCALE = 14'h0332;
  localparam logic [13:0] IDX_PID_TGT_SRC = 14'h0014;
  localparam logic [13:0] IDX_FREQ_SRC = 14'h0015;
  localparam logic [13:0] IDX_MAX_FREQ = 14'h0100;
  localparam logic [13:0] IDX_PID_COMP_SRC = 14'h0810;
  localparam logic [13:0] IDX_MAX_TORQUE = 14'h0b1b;
  localparam logic [13:0] IDX_RATED_TORQUE = 14'h0b1c;
  localparam logic [13:0] IDX_STATUS = 14'h03f0;
  localparam logic [13:0] IDX_FREQ_OUT = 14'h03f1;

  ////////////////////////////////////////////////////////////////////////////////
  // Function selector codes.
  localparam logic [15:0] FN_NONE = 16'h0000;
  localparam logic [15:0] FN_FREQ = 16'h0001;
  localparam logic [15:0] FN_TORQUE = 16'h0002;
  localparam logic [15:0] FN_TQ_COMP = 16'h0003;
  localparam logic [15:0] FN_PID_TARGET = 16'h0004;
  localparam logic [15:0] FN_PID_FEEDBACK = 16'h0005;
  localparam logic [15:0] FN_THERMISTOR = 16'h0006;
  localparam logic [15:0] FN_POS_TQ_LIMIT = 16'h0007;
  localparam logic [15:0] FN_NEG_TQ_LIMIT = 16'h0008;
  localparam logic [15:0] FN_REGEN_TQ_LIMIT = 16'h0009;
  localparam logic [15:0] FN_BOTH_TQ_LIMIT = 16'h000a;
  localparam logic [15:0] FN_RTD = 16'h000b;
  localparam logic [15:0] FN_AUX_FREQ = 16'h000c;
  localparam logic [15:0] FN_PID_COMP = 16'h000d;
  localparam int FN_COUNT = 13;

  // Bias modes.
  localparam logic [15:0] BM_NONE = 16'h0000;
  localparam logic [15:0] BM_FLOOR = 16'h0001;
  localparam logic [15:0] BM_ABS_CENTER = 16'h0003;
  localparam logic [15:0] BM_CENTER = 16'h0004;

  // Source codes and limits; percentages are in units of 0.1 %.
  localparam logic [15:0] PID_TGT_ANALOG = 16'h0002;
  localparam logic [15:0] PID_COMP_ANALOG = 16'h0001;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] AI_FULL = 16'h03e8;
  localparam logic signed [16:0] PCT_FULL = 17'sh003e8;
  localparam logic signed [15:0] BIAS_LIM = 16'sh03e8;
  localparam logic signed [15:0] GAIN_LIM = 16'sh1388;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  typedef struct packed {
    logic [15:0] func1;
    logic [15:0] func2;
    logic [15:0] bias1;
    logic [15:0] bias2;
    logic [15:0] mode1;
    logic [15:0] mode2;
    logic [15:0] rev_en;
    logic [15:0] gain1;
    logic [15:0] gain2;
    logic [15:0] add_en;
    logic [15:0] alt_sel;
    logic [15:0] pid_tgt_src;
    logic [15:0] pid_comp_src;
    logic [15:0] freq_src;
    logic [15:0] max_freq;
    logic [15:0] max_torque;
    logic [15:0] rated_torque;
  } cfg_type;

  localparam cfg_type CFG_RESET = '{func1: 16'h0001, func2: 16'h0000, bias1: 16'h0000,
    bias2: 16'h0000, mode1: 16'h0000, mode2: 16'h0000, rev_en: 16'h0000,
    gain1: 16'h03e8, gain2: 16'h03e8, add_en: 16'h0000, alt_sel: 16'h0000,
    pid_tgt_src: 16'h0000, pid_comp_src: 16'h0000, freq_src: 16'h0001,
    max_freq: 16'h1770, max_torque: 16'h03e8, rated_torque: 16'h03e8};

  typedef struct packed {
    logic signed [15:0] pct;
    logic neg;
  } scaled_type;

  typedef struct packed {
    cfg_type cfg;
    logic [15:0] ai1_m;
    logic [15:0] ai1_q;
    logic [15:0] ai2_m;
    logic [15:0] ai2_q;
    logic dir_m;
    logic dir_q;
    logic tog_m;
    logic tog_q;
    logic ack;
    logic [31:0] dat;
    logic rejected;
    logic signed [16:0] freq;
    logic freq_valid;
    logic reverse;
    logic signed [16:0] torque;
    logic torque_limit;
    logic signed [16:0] tcomp;
    logic signed [15:0] pid_target;
    logic pid_target_valid;
    logic signed [15:0] pid_comp;
    logic pid_comp_valid;
    logic [13:1][15:0] fn_pct;
    logic [13:1] fn_valid;
  } mapper_state_type;

endpackage

// File: design/ai_scaler.sv
// One analog input path: bias, bias mode and gain applied to a sample.
// Assumes the sample is already synchronised; full span is 0 to 1000 codes.
`timescale 1ns/1ps
`default_nettype none
module ai_scaler (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Sample and settings.
  input wire logic [15:0] sample_i,
  input wire logic [15:0] bias_i,
  input wire logic [15:0] mode_i,
  input wire logic [15:0] gain_i,
  input wire logic apply_i,
  input wire logic rev_en_i,
  // Scaled result in 0.1 % units.
  output aimap_pkg::scaled_type result_o
);

  aimap_pkg::scaled_type r;
  aimap_pkg::scaled_type n;
  logic signed [17:0] ps;
  logic signed [17:0] b;
  logic signed [17:0] babs;
  logic signed [17:0] v;
  logic signed [15:0] g;
  logic signed [33:0] prod;
  logic signed [33:0] sc;
  logic neg_ok;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ps = (sample_i > aimap_pkg::AI_FULL) ? $signed({2'h0, aimap_pkg::AI_FULL}) :
      $signed({2'h0, sample_i});
    b = $signed({{2{bias_i[15]}}, bias_i});
    babs = (b < 0) ? -b : b;
    g = apply_i ? $signed(gain_i) : $signed(aimap_pkg::CFG_RESET.gain1);
    v = ps;
    if (apply_i) begin
      case (mode_i)
        aimap_pkg::BM_FLOOR: v = (ps <= b) ? b : ps;
        aimap_pkg::BM_ABS_CENTER: v = ps - babs;
        aimap_pkg::BM_CENTER: v = ps - b;
        default: v = ps;
      endcase
    end
    prod = v * g;
    sc = prod / 34'(aimap_pkg::PCT_FULL);
    // Only a centred bias with negative gain and reverse allowed may go below zero.
    neg_ok = apply_i && (mode_i == aimap_pkg::BM_CENTER) && g[15] && rev_en_i;
    n.pct = (sc < 0 && !neg_ok) ? 16'sh0000 : sc[15:0];
    n.neg = (sc < 0) && neg_ok;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign result_o = r;

  ////////////////////////////////////////////////////////////////////////////////
  neg_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.neg |-> $past(apply_i && mode_i == aimap_pkg::BM_CENTER && gain_i[15] && rev_en_i))
    else $error("negative without its cause");

  raw_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !apply_i |=> r.pct == $past(ps[15:0]))
    else $error("settings not ignored");

endmodule
`default_nettype wire

// File: design/ai_function_mapper.sv
// Analog input function mapper: two inputs, function selection, scaling and
// direction, with its settings on a classic Wishbone slave.
// Assumes analog samples and direction pins arrive asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ai_function_mapper (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Terminal inputs.
  input wire logic [15:0] first_analog_input_i,
  input wire logic [15:0] second_analog_input_i,
  input wire logic dir_reverse_i,
  input wire logic torque_speed_mode_toggle_i,
  // Frequency and direction.
  output logic signed [16:0] freq_cmd_o,
  output logic freq_valid_o,
  output logic run_reverse_o,
  // Torque.
  output logic signed [16:0] torque_cmd_o,
  output logic torque_is_limit_o,
  output logic signed [16:0] torque_comp_o,
  // PID.
  output logic signed [15:0] pid_target_o,
  output logic pid_target_valid_o,
  output logic signed [15:0] pid_comp_o,
  output logic pid_comp_valid_o,
  // Per-function values in 0.1 % units.
  output logic [13:1][15:0] fn_pct_o,
  output logic [13:1] fn_valid_o
);

  aimap_pkg::mapper_state_type r;
  aimap_pkg::mapper_state_type n;
  aimap_pkg::scaled_type s1;
  aimap_pkg::scaled_type s2;
  logic apply;
  logic rev_eff;
  logic [13:0] idx;
  logic hit;
  logic wr_now;
  logic [15:0] cur;
  logic [31:0] rd;
  logic [15:0] wv;
  logic ok;
  logic signed [16:0] freq_sum;
  logic signed [16:0] freq_gated;
  logic [13:1] hit1;
  logic [13:1] hit2;
  logic [13:1][15:0] pctw;

  // Scales a percentage, clamped to the full span, onto a full-scale value.
  function automatic logic signed [16:0] scale_by(input logic signed [16:0] pct,
                                                  input logic [15:0] full);
    logic signed [16:0] c;
    logic signed [33:0] p;
    logic signed [33:0] q;
    c = (pct > aimap_pkg::PCT_FULL) ? aimap_pkg::PCT_FULL :
      ((pct < -aimap_pkg::PCT_FULL) ? -aimap_pkg::PCT_FULL : pct);
    p = c * $signed({1'b0, full});
    q = p / 34'(aimap_pkg::PCT_FULL);
    return q[16:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input paths.
  assign apply = (r.cfg.alt_sel == 16'h0000) && r.cfg.freq_src[0];
  assign rev_eff = apply && r.cfg.rev_en[0];

  ai_scaler in1_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(r.ai1_q),
    .bias_i(r.cfg.bias1),
    .mode_i(r.cfg.mode1),
    .gain_i(r.cfg.gain1),
    .apply_i(apply),
    .rev_en_i(rev_eff),
    .result_o(s1)
  );

  ai_scaler in2_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(r.ai2_q),
    .bias_i(r.cfg.bias2),
    .mode_i(r.cfg.mode2),
    .gain_i(r.cfg.gain2),
    .apply_i(apply),
    .rev_en_i(rev_eff),
    .result_o(s2)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Function decode, one entry per selector code from FN_FREQ to FN_PID_COMP.
  for (genvar f = 1; f <= aimap_pkg::FN_COUNT; f++) begin : g_fn
    assign hit1[f] = (r.cfg.func1 == 16'(f));
    assign hit2[f] = (r.cfg.func2 == 16'(f));
    assign pctw[f] = hit1[f] ? s1.pct : s2.pct;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  assign idx = adr_i[15:2];
  assign hit = cyc_i && stb_i;
  assign wr_now = hit && we_i && r.ack;

  always_comb begin
    cur = 16'h0000;
    rd = 32'h0000_0000;
    case (idx)
      aimap_pkg::IDX_IN1_FUNC: cur = r.cfg.func1;
      aimap_pkg::IDX_IN2_FUNC: cur = r.cfg.func2;
      aimap_pkg::IDX_IN1_BIAS: cur = r.cfg.bias1;
      aimap_pkg::IDX_IN2_BIAS: cur = r.cfg.bias2;
      aimap_pkg::IDX_IN1_MODE: cur = r.cfg.mode1;
      aimap_pkg::IDX_IN2_MODE: cur = r.cfg.mode2;
      aimap_pkg::IDX_REV_EN: cur = r.cfg.rev_en;
      aimap_pkg::IDX_IN1_GAIN: cur = r.cfg.gain1;
      aimap_pkg::IDX_IN2_GAIN: cur = r.cfg.gain2;
      aimap_pkg::IDX_ADD_EN: cur = r.cfg.add_en;
      aimap_pkg::IDX_ALT_SCALE: cur = r.cfg.alt_sel;
      aimap_pkg::IDX_PID_TGT_SRC: cur = r.cfg.pid_tgt_src;
      aimap_pkg::IDX_PID_COMP_SRC: cur = r.cfg.pid_comp_src;
      aimap_pkg::IDX_FREQ_SRC: cur = r.cfg.freq_src;
      aimap_pkg::IDX_MAX_FREQ: cur = r.cfg.max_freq;
      aimap_pkg::IDX_MAX_TORQUE: cur = r.cfg.max_torque;
      aimap_pkg::IDX_RATED_TORQUE: cur = r.cfg.rated_torque;
      aimap_pkg::IDX_STATUS: cur = {13'h0000, r.freq_valid, r.reverse, r.rejected};
      default: cur = 16'h0000;
    endcase
    if (idx == aimap_pkg::IDX_FREQ_OUT) begin
      rd = {{15{r.freq[16]}}, r.freq};
    end else begin
      rd = {16'h0000, cur};
    end
    wv[7:0] = sel_i[0] ? dat_i[7:0] : cur[7:0];
    wv[15:8] = sel_i[1] ? dat_i[15:8] : cur[15:8];
    case (idx)
      aimap_pkg::IDX_IN1_FUNC, aimap_pkg::IDX_IN2_FUNC: ok = (wv <= aimap_pkg::FN_PID_COMP);
      aimap_pkg::IDX_IN1_BIAS, aimap_pkg::IDX_IN2_BIAS:
        ok = ($signed(wv) >= -aimap_pkg::BIAS_LIM) && ($signed(wv) <= aimap_pkg::BIAS_LIM);
      aimap_pkg::IDX_IN1_GAIN, aimap_pkg::IDX_IN2_GAIN:
        ok = ($signed(wv) >= -aimap_pkg::GAIN_LIM) && ($signed(wv) <= aimap_pkg::GAIN_LIM);
      aimap_pkg::IDX_IN1_MODE, aimap_pkg::IDX_IN2_MODE:
        ok = (wv == aimap_pkg::BM_NONE) || (wv == aimap_pkg::BM_FLOOR) ||
          (wv == aimap_pkg::BM_ABS_CENTER) || (wv == aimap_pkg::BM_CENTER);
      aimap_pkg::IDX_REV_EN, aimap_pkg::IDX_ADD_EN, aimap_pkg::IDX_FREQ_SRC:
        ok = (wv <= aimap_pkg::FLAG_MAX);
      default: ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    n = r;
    // Two-stage synchronisers for the terminal inputs.
    n.ai1_m = first_analog_input_i;
    n.ai1_q = r.ai1_m;
    n.ai2_m = second_analog_input_i;
    n.ai2_q = r.ai2_m;
    n.dir_m = dir_reverse_i;
    n.dir_q = r.dir_m;
    n.tog_m = torque_speed_mode_toggle_i;
    n.tog_q = r.tog_m;

    // Answer one cycle after the request; the write lands on the ack edge.
    n.ack = hit && !r.ack;
    n.dat = rd;
    if (wr_now && (idx == aimap_pkg::IDX_STATUS) && wv[0]) begin
      n.rejected = 1'b0;
    end
    if (wr_now && !ok) begin
      n.rejected = 1'b1;
    end else if (wr_now) begin
      case (idx)
        aimap_pkg::IDX_IN1_FUNC: n.cfg.func1 = wv;
        aimap_pkg::IDX_IN2_FUNC: n.cfg.func2 = wv;
        aimap_pkg::IDX_IN1_BIAS: n.cfg.bias1 = wv;
        aimap_pkg::IDX_IN2_BIAS: n.cfg.bias2 = wv;
        aimap_pkg::IDX_IN1_MODE: n.cfg.mode1 = wv;
        aimap_pkg::IDX_IN2_MODE: n.cfg.mode2 = wv;
        aimap_pkg::IDX_REV_EN: n.cfg.rev_en = wv;
        aimap_pkg::IDX_IN1_GAIN: n.cfg.gain1 = wv;
        aimap_pkg::IDX_IN2_GAIN: n.cfg.gain2 = wv;
        aimap_pkg::IDX_ADD_EN: n.cfg.add_en = wv;
        aimap_pkg::IDX_ALT_SCALE: n.cfg.alt_sel = wv;
        aimap_pkg::IDX_PID_TGT_SRC: n.cfg.pid_tgt_src = wv;
        aimap_pkg::IDX_PID_COMP_SRC: n.cfg.pid_comp_src = wv;
        aimap_pkg::IDX_FREQ_SRC: n.cfg.freq_src = wv;
        aimap_pkg::IDX_MAX_FREQ: n.cfg.max_freq = wv;
        aimap_pkg::IDX_MAX_TORQUE: n.cfg.max_torque = wv;
        aimap_pkg::IDX_RATED_TORQUE: n.cfg.rated_torque = wv;
        default: n.cfg = r.cfg;
      endcase
    end

    // Frequency command and direction.
    if (hit1[1] && hit2[1] && r.cfg.add_en[0]) begin
      freq_sum = 17'(s1.pct) + 17'(s2.pct);
    end else if (hit1[1]) begin
      freq_sum = 17'(s1.pct);
    end else if (hit2[1]) begin
      freq_sum = 17'(s2.pct);
    end else begin
      freq_sum = 17'sh00000;
    end
    freq_gated = (freq_sum < 0 && !rev_eff) ? 17'sh00000 : freq_sum;
    n.freq = scale_by(freq_gated, r.cfg.max_freq);
    n.freq_valid = hit1[1] || hit2[1];
    n.reverse = rev_eff ? (freq_gated < 0) : r.dir_q;

    // Torque command or limit, and torque compensation.
    n.torque = scale_by(17'($signed(pctw[2])), r.cfg.max_torque);
    n.torque_limit = (hit1[2] || hit2[2]) && r.tog_q;
    n.tcomp = scale_by(17'($signed(pctw[3])), r.cfg.rated_torque);

    // PID target: a frequency or target selection on the first input wins.
    if (hit1[1] || hit1[4]) begin
      n.pid_target = s1.pct;
      n.pid_target_valid = (r.cfg.pid_tgt_src == aimap_pkg::PID_TGT_ANALOG);
    end else if (hit2[1] || hit2[4]) begin
      n.pid_target = s2.pct;
      n.pid_target_valid = (r.cfg.pid_tgt_src == aimap_pkg::PID_TGT_ANALOG);
    end else begin
      n.pid_target = 16'sh0000;
      n.pid_target_valid = 1'b0;
    end
    n.pid_comp = pctw[13];
    n.pid_comp_valid = (hit1[13] || hit2[13]) &&
      (r.cfg.pid_comp_src == aimap_pkg::PID_COMP_ANALOG);

    n.fn_pct = pctw;
    n.fn_valid = hit1 | hit2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.cfg <= aimap_pkg::CFG_RESET;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign freq_cmd_o = r.freq;
  assign freq_valid_o = r.freq_valid;
  assign run_reverse_o = r.reverse;
  assign torque_cmd_o = r.torque;
  assign torque_is_limit_o = r.torque_limit;
  assign torque_comp_o = r.tcomp;
  assign pid_target_o = r.pid_target;
  assign pid_target_valid_o = r.pid_target_valid;
  assign pid_comp_o = r.pid_comp;
  assign pid_comp_valid_o = r.pid_comp_valid;
  assign fn_pct_o = r.fn_pct;
  assign fn_valid_o = r.fn_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_timing_a: assert property (hit && !ack_o |=> ack_o) else $error("ack late");
  reject_keep_a: assert property (wr_now && idx == aimap_pkg::IDX_IN1_FUNC &&
    wv > aimap_pkg::FN_PID_COMP |=> $stable(r.cfg.func1) && r.rejected)
    else $error("bad selector write stored");
  first_wins_a: assert property (r.cfg.func1 == r.cfg.func2 &&
    r.cfg.func1 == aimap_pkg::FN_FREQ |=> fn_pct_o[1] == $past(s1.pct))
    else $error("second input won a tie");
  pid_pick_a: assert property (((r.cfg.func1 == aimap_pkg::FN_FREQ &&
    r.cfg.func2 == aimap_pkg::FN_PID_TARGET) || (r.cfg.func1 == aimap_pkg::FN_PID_TARGET &&
    r.cfg.func2 == aimap_pkg::FN_FREQ)) |=> pid_target_o == $past(s1.pct))
    else $error("wrong PID target input");
  no_negative_a: assert property (!rev_eff |=> freq_cmd_o >= 0)
    else $error("negative frequency without reverse enable");
  dir_terminal_a: assert property (!rev_eff |=> run_reverse_o == $past(r.dir_q))
    else $error("direction not from terminals");
  dir_sign_a: assert property (rev_eff |=> run_reverse_o == $past(freq_gated < 0))
    else $error("direction not from sign");

endmodule
`default_nettype wire

// File: dv/analog_sensor_model.sv
// Model of the sensors and terminal switches wired to the drive's inputs.
// Assumes the bench sets the wanted levels; they appear just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module analog_sensor_model (
  // Clock.
  input wire logic clk_i,
  // Wanted levels.
  input wire logic [15:0] lvl1_i,
  input wire logic [15:0] lvl2_i,
  input wire logic rev_i,
  input wire logic tog_i,
  // Terminal lines.
  output logic [15:0] ai1_o,
  output logic [15:0] ai2_o,
  output logic rev_o,
  output logic tog_o
);
  initial begin
    {ai1_o, ai2_o, rev_o, tog_o} = '0;
  end
  always @(posedge clk_i) begin
    {ai1_o, ai2_o, rev_o, tog_o} <= {lvl1_i, lvl2_i, rev_i, tog_i};
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the analog input function mapper.
// Assumes classic Wishbone answers within 50 clocks and outputs settled within eight clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic w;
    logic [13:0] idx;
    logic [15:0] d;
    logic [15:0] exp;
  } row_type;
  logic clk_i, rst_i, cyc, stb, we, rev, tog, ack, rev_w, tog_w;
  logic fv, rr, tl, ptv, pcv;
  logic [15:0] adr, lvl1, lvl2, ai1, ai2, pt, pc;
  logic [3:0] sel;
  logic [31:0] dat, rd, dat_o;
  logic signed [16:0] freq, tq, tc;
  logic [13:1][15:0] fn_pct;
  logic [13:1] fn_valid;
  int n_fail, n_compared;
  row_type rows [16] = '{
    '{1'b0, aimap_pkg::IDX_IN1_FUNC, 16'h0000, 16'h0001},
    '{1'b0, aimap_pkg::IDX_IN2_FUNC, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_IN1_BIAS, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_IN2_BIAS, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_IN1_MODE, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_IN2_MODE, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_REV_EN, 16'h0000, 16'h0000},
    '{1'b0, aimap_pkg::IDX_IN1_GAIN, 16'h0000, 16'h03e8},
    '{1'b0, aimap_pkg::IDX_IN2_GAIN, 16'h0000, 16'h03e8},
    '{1'b1, aimap_pkg::IDX_IN1_BIAS, 16'h03e9, 16'h0000},
    '{1'b1, aimap_pkg::IDX_IN2_MODE, 16'h0002, 16'h0000},
    '{1'b1, aimap_pkg::IDX_IN2_GAIN, 16'hec77, 16'h03e8},
    '{1'b1, aimap_pkg::IDX_IN1_FUNC, 16'h000e, 16'h0001},
    '{1'b1, 14'h0200, 16'h0005, 16'h0000},
    '{1'b0, aimap_pkg::IDX_STATUS, 16'h0000, 16'h0005},
    '{1'b1, aimap_pkg::IDX_STATUS, 16'h0001, 16'h0004}};

  analog_sensor_model analog_sensor_model_inst (.clk_i(clk_i), .lvl1_i(lvl1), .lvl2_i(lvl2),
    .rev_i(rev), .tog_i(tog), .ai1_o(ai1), .ai2_o(ai2), .rev_o(rev_w), .tog_o(tog_w));
  ai_function_mapper ai_function_mapper_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .first_analog_input_i(ai1), .second_analog_input_i(ai2), .dir_reverse_i(rev_w),
    .torque_speed_mode_toggle_i(tog_w), .freq_cmd_o(freq), .freq_valid_o(fv),
    .run_reverse_o(rr), .torque_cmd_o(tq), .torque_is_limit_o(tl), .torque_comp_o(tc),
    .pid_target_o(pt), .pid_target_valid_o(ptv), .pid_comp_o(pc), .pid_comp_valid_o(pcv),
    .fn_pct_o(fn_pct), .fn_valid_o(fn_valid));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled high.
  task wb(input logic w, input logic [13:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, idx, 2'b00, 16'h0, d, 4'h3};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      end_of_test;
    end
  endtask

  task settle;
    repeat (8) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, cyc, stb, we, adr, sel, dat, lvl1, lvl2, rev, tog} = {1'b1, 89'h0};
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    chk(32'(fn_valid), 32'h0);
    rst_i <= 1'b0;
    settle;
    foreach (rows[i]) begin
      if (rows[i].w) wb(1'b1, rows[i].idx, rows[i].d);
      wb(1'b0, rows[i].idx, 16'h0);
      chk({16'h0, rd[15:0]}, {16'h0, rows[i].exp});
    end
    lvl1 <= 16'd500;
    lvl2 <= 16'd300;
    wb(1'b1, aimap_pkg::IDX_IN2_FUNC, 16'h0001);
    settle;
    chk(32'(freq), 32'd3000);
    chk(32'(fn_pct[1]), 32'd500);
    chk(32'({fv, fn_valid}), 32'h2001);
    wb(1'b1, aimap_pkg::IDX_ADD_EN, 16'h0001);
    settle;
    chk(32'(freq), 32'd4800);
    wb(1'b1, aimap_pkg::IDX_IN2_FUNC, 16'h0002);
    tog <= 1'b1;
    wb(1'b1, aimap_pkg::IDX_IN1_FUNC, 16'h0003);
    settle;
    chk(32'(tq), 32'd300);
    chk(32'(tl), 32'h1);
    chk(32'(tc), 32'd500);
    wb(1'b1, aimap_pkg::IDX_IN1_FUNC, 16'h0004);
    wb(1'b1, aimap_pkg::IDX_IN2_FUNC, 16'h0001);
    settle;
    chk(32'(ptv), 32'h0);
    wb(1'b1, aimap_pkg::IDX_PID_TGT_SRC, 16'h0002);
    settle;
    chk({ptv, 15'h0, pt}, {1'b1, 15'h0, 16'd500});
    wb(1'b1, aimap_pkg::IDX_IN2_FUNC, 16'h000d);
    wb(1'b1, aimap_pkg::IDX_PID_COMP_SRC, 16'h0001);
    settle;
    chk({pcv, 15'h0, pc}, {1'b1, 15'h0, 16'd300});
    wb(1'b1, aimap_pkg::IDX_IN1_FUNC, 16'h0001);
    wb(1'b1, aimap_pkg::IDX_IN2_FUNC, 16'h0000);
    wb(1'b1, aimap_pkg::IDX_IN1_MODE, 16'h0004);
    wb(1'b1, aimap_pkg::IDX_IN1_BIAS, 16'h01f4);
    wb(1'b1, aimap_pkg::IDX_IN1_GAIN, 16'hfc18);
    wb(1'b1, aimap_pkg::IDX_REV_EN, 16'h0001);
    lvl1 <= 16'd800;
    settle;
    chk(32'(freq), -32'sd1800);
    chk(32'(rr), 32'h1);
    wb(1'b1, aimap_pkg::IDX_REV_EN, 16'h0000);
    rev <= 1'b1;
    settle;
    chk(32'(freq), 32'd0);
    chk(32'(rr), 32'h1);
    wb(1'b1, aimap_pkg::IDX_REV_EN, 16'h0001);
    wb(1'b1, aimap_pkg::IDX_ALT_SCALE, 16'h0001);
    rev <= 1'b0;
    settle;
    chk({rr, 15'h0, 16'(freq)}, {1'b0, 15'h0, 16'd4800});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, aimap_pkg::IDX_IN1_BIAS, 16'h0000);
    chk(32'(rd[15:0]), 32'h0);
    wb(1'b0, aimap_pkg::IDX_IN1_GAIN, 16'h0000);
    chk(32'(rd[15:0]), 32'h03e8);
    wb(1'b1, aimap_pkg::IDX_IN1_MODE, 16'h0003);
    wb(1'b1, aimap_pkg::IDX_IN1_BIAS, 16'hff38);
    settle;
    chk(32'(freq), 32'd3600);
    wb(1'b1, aimap_pkg::IDX_IN1_MODE, 16'h0001);
    wb(1'b1, aimap_pkg::IDX_IN1_BIAS, 16'h0384);
    settle;
    chk(32'(freq), 32'd5400);
    end_of_test;
  end
endmodule
`default_nettype wire
